// file: core/reset_wdog_pkg.sv
package reset_wdog_pkg;

  // bus map, byte addresses of aligned words
  localparam logic [7:0] WATCHDOG_CONTROL_STATUS_ADDR = 8'h00;
  localparam logic [7:0] RESET_CAUSE_ADDR             = 8'h04;
  localparam logic [7:0] RESET_CONTROL_ADDR           = 8'h08;
  localparam logic [7:0] STATUS_ADDR                  = 8'h0C;

  // watchdog_control_status field positions
  localparam int WDOG_IRQ_FLAG_BIT  = 7;
  localparam int WDOG_IRQ_EN_BIT    = 6;
  localparam int WDOG_PRESC_HI_BIT  = 5;
  localparam int WDOG_CHG_EN_BIT    = 4;
  localparam int WDOG_RST_EN_BIT    = 3;
  localparam int WDOG_PRESC_LO_MSB  = 2;

  // reset cause field positions
  localparam int CAUSE_SCAN_BIT     = 4;
  localparam int CAUSE_WDOG_BIT     = 3;
  localparam int CAUSE_BROWNOUT_BIT = 2;
  localparam int CAUSE_PIN_BIT      = 1;
  localparam int CAUSE_POWERON_BIT  = 0;

  localparam logic [7:0] WDOG_CTRL_RESET  = 8'h00;
  localparam logic [4:0] CAUSE_RESET      = 5'h00;
  localparam logic [1:0] BOOT_CTRL_RESET  = 2'h0;

  // timing
  localparam int REF_CLK_HZ         = 25000000;
  localparam int WDOG_OSC_HZ        = 128000;
  localparam int CHANGE_WINDOW_CYC  = 4;
  // watchdog 2K osc cycles is 16 ms; index n up to 9 gives 2K << n, higher codes give 2K << 9
  localparam int WDOG_BASE_OSC_CYC  = 2048;
  localparam int WDOG_MAX_SELECT    = 9;

  typedef struct packed {
    logic        poweron;
    logic        pin;
    logic        brownout;
    logic        wdog;
    logic        scan;
  } reset_src_t;

  typedef struct packed {
    logic        irqFlag;
    logic        irqEn;
    logic        chgEn;
    logic        rstEn;
    logic [3:0]  presc;
  } wdog_ctrl_t;

endpackage : reset_wdog_pkg

// file: core/system_reset_and_watchdog.sv
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module system_reset_and_watchdog
  import reset_wdog_pkg::*;
#(
  parameter int DELAY_CYC      = 1024,
  parameter int BOD_FILTER_CYC = 50,
  parameter int OSC_DIV        = REF_CLK_HZ / WDOG_OSC_HZ
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        powerGood,
  input  wire logic        resetPinN,
  input  wire logic        brownoutLow,
  input  wire logic        scanResetBit,
  input  wire logic        pin_reset_disable_fuse,
  input  wire logic        watchdog_always_on_fuse,
  input  wire logic        brownoutEnableFuse,
  input  wire logic        comparator_bandgap_select,
  input  wire logic        converterEnable,
  input  wire logic        watchdogRestart,
  input  wire logic        wdogVectorAck,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             portResetN,
  output logic             internalReset,
  output logic             resetVectorStart,
  output logic             wdogIrq,
  output logic             bandgapEnable
);

  localparam int DW = $clog2(DELAY_CYC + 1);
  localparam int BW = $clog2(BOD_FILTER_CYC + 1);
  localparam int OW = $clog2(OSC_DIV + 1);
  localparam int WW = 21;

  typedef enum {RUNNING, HOLDING, STRETCHING} seq_state_t;

  // watchdog limit in osc cycles for a prescaler code
  function automatic logic [WW-1:0] wdogLimit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > 4'(WDOG_MAX_SELECT)) ? 4'(WDOG_MAX_SELECT) : sel;
    wdogLimit = WW'(WDOG_BASE_OSC_CYC) << s;
  endfunction : wdogLimit

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  logic [2:0]  pinSync_ff;
  logic [2:0]  bodSync_ff;
  logic [2:0]  pgSync_ff;
  logic [2:0]  scanSync_ff;
  logic        pinLow_ff;
  logic        bodRaw_ff;
  logic        pgOk_ff;
  logic        scanHeld_ff;

  always_ff @(posedge ref_clk) begin
    pinSync_ff  <= {pinSync_ff[1:0], ~resetPinN};
    bodSync_ff  <= {bodSync_ff[1:0], brownoutLow};
    pgSync_ff   <= {pgSync_ff[1:0], powerGood};
    scanSync_ff <= {scanSync_ff[1:0], scanResetBit};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinLow_ff   <= 1'b0;
      bodRaw_ff   <= 1'b0;
      pgOk_ff     <= 1'b0;
      scanHeld_ff <= 1'b0;
    end else begin
      if (pinSync_ff[2] == pinSync_ff[1]) pinLow_ff <= pinSync_ff[2];
      if (bodSync_ff[2] == bodSync_ff[1]) bodRaw_ff <= bodSync_ff[2];
      if (pgSync_ff[2] == pgSync_ff[1]) pgOk_ff <= pgSync_ff[2];
      if (scanSync_ff[2] == scanSync_ff[1]) scanHeld_ff <= scanSync_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // brown-out filter: short dips reach the raw portResetN path but never the internal reset sources
  logic [BW-1:0] bodCnt_ff;
  logic          bodLow_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bodCnt_ff <= '0;
      bodLow_ff <= 1'b0;
    end else if (!bodRaw_ff) begin
      bodCnt_ff <= '0;
      bodLow_ff <= 1'b0;
    end else if (bodCnt_ff >= BW'(BOD_FILTER_CYC)) begin
      bodLow_ff <= 1'b1;
    end else begin
      bodCnt_ff <= bodCnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset tree
  reset_src_t src;
  logic       wdogPulse_ff;
  logic       anySource;

  always_comb begin
    src.poweron  = ~pgOk_ff;
    src.pin      = pinLow_ff & ~pin_reset_disable_fuse;
    src.brownout = bodLow_ff & brownoutEnableFuse;
    src.wdog     = wdogPulse_ff;
    src.scan     = scanHeld_ff;
    anySource    = |src;
  end

  // raw asynchronous path for the port pins; only the watchdog term (wdogPulse_ff) is clocked
  assign portResetN = ~(srst | ~powerGood | (~resetPinN & ~pin_reset_disable_fuse)
                        | (brownoutLow & brownoutEnableFuse) | scanResetBit
                        | wdogPulse_ff);

  seq_state_t    state_ff;
  logic [DW-1:0] delay_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= HOLDING;
      delay_ff <= '0;
    end else begin
      case (state_ff)
        RUNNING: begin
          if (anySource) state_ff <= HOLDING;
        end
        HOLDING: begin
          delay_ff <= '0;
          if (!anySource) state_ff <= STRETCHING;
        end
        STRETCHING: begin
          if (anySource) begin
            state_ff <= HOLDING;
          end else if (delay_ff >= DW'(DELAY_CYC - 1)) begin
            state_ff <= RUNNING;
          end else begin
            delay_ff <= delay_ff + 1'b1;
          end
        end
        default: state_ff <= HOLDING;
      endcase
    end
  end

  logic runPrev_ff;
  always_ff @(posedge ref_clk) begin
    if (srst) runPrev_ff <= 1'b0;
    else runPrev_ff <= (state_ff == RUNNING);
  end

  // core restarts at vector on first running cycle
  assign internalReset    = (state_ff != RUNNING) | anySource;
  assign resetVectorStart = (state_ff == RUNNING) & ~runPrev_ff;
  assign bandgapEnable    = brownoutEnableFuse | comparator_bandgap_select
                            | converterEnable;

  ////////////////////////////////////////////////////////////////////
  // watchdog oscillator enable and counter; no sleep input by design
  logic [OW-1:0] oscDiv_ff;
  logic          oscTick;
  logic [WW-1:0] wdogCnt_ff;
  wdog_ctrl_t    ctrl_ff;
  logic          wdogOn;
  logic          expire;
  logic          effRstEn;
  logic          effIrqEn;
  logic [4:0]    cause_ff;

  assign oscTick = (oscDiv_ff == OW'(OSC_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (srst) oscDiv_ff <= '0;
    else if (oscTick) oscDiv_ff <= '0;
    else oscDiv_ff <= oscDiv_ff + 1'b1;
  end

  assign effRstEn = watchdog_always_on_fuse | ctrl_ff.rstEn
                    | cause_ff[CAUSE_WDOG_BIT];
  assign effIrqEn = ctrl_ff.irqEn & ~watchdog_always_on_fuse;
  assign wdogOn   = effRstEn | effIrqEn;
  assign expire   = wdogOn & oscTick
                    & (wdogCnt_ff >= wdogLimit(ctrl_ff.presc) - 1'b1);

  always_ff @(posedge ref_clk) begin
    if (srst || watchdogRestart || !wdogOn || internalReset) begin
      wdogCnt_ff <= '0;
    end else if (oscTick) begin
      wdogCnt_ff <= expire ? '0 : wdogCnt_ff + 1'b1;
    end
  end

  // reset fires when reset enabled and interrupt not enabled
  always_ff @(posedge ref_clk) begin
    if (srst) wdogPulse_ff <= 1'b0;
    else wdogPulse_ff <= expire & effRstEn & ~effIrqEn;
  end

  ////////////////////////////////////////////////////////////////////
  // register bus
  logic       busReq;
  logic       wrCtrl;
  logic       wrCause;
  logic [7:0] wrByte;
  logic [2:0] chgWin_ff;
  logic       winOpen;
  logic [1:0] bootCtrl_ff;

  assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrByte  = wb_dat_i[7:0];
  assign wrCtrl  = busReq & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == WATCHDOG_CONTROL_STATUS_ADDR);
  assign wrCause = busReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == RESET_CAUSE_ADDR);
  assign winOpen = ctrl_ff.chgEn;

  always_ff @(posedge ref_clk) begin
    if (srst) wb_ack_o <= 1'b0;
    else wb_ack_o <= busReq;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_ff   <= WDOG_CTRL_RESET;
      chgWin_ff <= '0;
    end else begin
      // interrupt flag: hardware set wins over clear
      if (expire && effIrqEn) begin
        ctrl_ff.irqFlag <= 1'b1;
      end else if (wdogVectorAck) begin
        ctrl_ff.irqFlag <= 1'b0;
      end else if (wrCtrl && wrByte[WDOG_IRQ_FLAG_BIT]) begin
        ctrl_ff.irqFlag <= 1'b0;
      end
      if (wdogVectorAck && effRstEn) begin
        ctrl_ff.irqEn <= 1'b0;
      end else if (wrCtrl) begin
        ctrl_ff.irqEn <= wrByte[WDOG_IRQ_EN_BIT];
      end
      if (wrCtrl && wrByte[WDOG_CHG_EN_BIT] && wrByte[WDOG_RST_EN_BIT]) begin
        ctrl_ff.chgEn <= 1'b1;
        ctrl_ff.rstEn <= 1'b1;
        chgWin_ff     <= 3'(CHANGE_WINDOW_CYC);
      end else if (wrCtrl && winOpen && !wrByte[WDOG_CHG_EN_BIT]) begin
        ctrl_ff.rstEn <= wrByte[WDOG_RST_EN_BIT];
        ctrl_ff.presc <= {wrByte[WDOG_PRESC_HI_BIT], wrByte[WDOG_PRESC_LO_MSB:0]};
        ctrl_ff.chgEn <= 1'b0;
        chgWin_ff     <= '0;
      end else begin
        if (wrCtrl && wrByte[WDOG_RST_EN_BIT]) ctrl_ff.rstEn <= 1'b1;
        if (chgWin_ff == 3'h1) ctrl_ff.chgEn <= 1'b0;
        if (chgWin_ff != 3'h0) chgWin_ff <= chgWin_ff - 3'h1;
      end
    end
  end

  // cause flags: power-on clears the rest; hardware set beats clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cause_ff <= CAUSE_RESET;
    end else if (src.poweron) begin
      cause_ff <= 5'h01;
    end else begin
      cause_ff[CAUSE_POWERON_BIT]  <= cause_ff[CAUSE_POWERON_BIT]
                                    & ~(wrCause & ~wrByte[CAUSE_POWERON_BIT]);
      cause_ff[CAUSE_PIN_BIT]      <= src.pin | (cause_ff[CAUSE_PIN_BIT]
                                    & ~(wrCause & ~wrByte[CAUSE_PIN_BIT]));
      cause_ff[CAUSE_BROWNOUT_BIT] <= src.brownout | (cause_ff[CAUSE_BROWNOUT_BIT]
                                    & ~(wrCause & ~wrByte[CAUSE_BROWNOUT_BIT]));
      cause_ff[CAUSE_WDOG_BIT]     <= src.wdog | (cause_ff[CAUSE_WDOG_BIT]
                                    & ~(wrCause & ~wrByte[CAUSE_WDOG_BIT]));
      cause_ff[CAUSE_SCAN_BIT]     <= src.scan | (cause_ff[CAUSE_SCAN_BIT]
                                    & ~(wrCause & ~wrByte[CAUSE_SCAN_BIT]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) bootCtrl_ff <= BOOT_CTRL_RESET;
    else if (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == RESET_CONTROL_ADDR)
      bootCtrl_ff <= wrByte[1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_dat_o <= '0;
    end else if (busReq && !wb_we_i) begin
      case (wb_adr_i)
        WATCHDOG_CONTROL_STATUS_ADDR:
          wb_dat_o <= {24'h000000, ctrl_ff.irqFlag, effIrqEn, ctrl_ff.presc[3],
                       ctrl_ff.chgEn, effRstEn, ctrl_ff.presc[2:0]};
        RESET_CAUSE_ADDR:   wb_dat_o <= {27'h0000000, cause_ff};
        RESET_CONTROL_ADDR: wb_dat_o <= {30'h00000000, bootCtrl_ff};
        STATUS_ADDR:        wb_dat_o <= {29'h00000000, bandgapEnable, wdogOn,
                                         internalReset};
        default:            wb_dat_o <= '0;
      endcase
    end
  end

  // interrupt only when enabled; wakes from sleep as a plain level
  assign wdogIrq = ctrl_ff.irqFlag & effIrqEn;

endmodule : system_reset_and_watchdog

// file: test/system_reset_and_watchdog_assertions.sv
`timescale 1ns/10ps
module reset_wdog_checker #(
  parameter int DELAY_CYC = 1024
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic powerGood,
  input wire logic resetPinN,
  input wire logic brownoutLow,
  input wire logic scanResetBit,
  input wire logic pin_reset_disable_fuse,
  input wire logic watchdog_always_on_fuse,
  input wire logic brownoutEnableFuse,
  input wire logic comparator_bandgap_select,
  input wire logic converterEnable,
  input wire logic wdogVectorAck,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic portResetN,
  input wire logic internalReset,
  input wire logic resetVectorStart,
  input wire logic wdogIrq,
  input wire logic bandgapEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [15:0] quietCnt_ff;
  // cycles since the raw reset net was last low at an edge
  always_ff @(posedge ref_clk) begin
    if (srst || !portResetN) quietCnt_ff <= 16'h0000;
    else if (quietCnt_ff != 16'hFFFF) quietCnt_ff <= quietCnt_ff + 16'h0001;
  end
  sequence released_s; $past(internalReset) && !internalReset; endsequence
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  ////////////////////////////////////////////////////////////////
  a_release_after_delay:
    assert property (released_s |-> quietCnt_ff >= DELAY_CYC) else $error("early release");
  a_ack_one_cycle:
    assert property (take_s |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack timing");
  a_ack_needs_req:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_pin_resets_port:
    assert property (!resetPinN && !pin_reset_disable_fuse |-> !portResetN)
      else $error("pin not reset");
  a_scan_holds_reset:
    assert property (scanResetBit [*5] |-> internalReset) else $error("scan not held");
  a_bandgap_or:
    assert property (bandgapEnable == (brownoutEnableFuse || comparator_bandgap_select
      || converterEnable)) else $error("bandgap wrong");
  a_fuse_no_irq:
    assert property (watchdog_always_on_fuse |-> !wdogIrq) else $error("irq with fuse");
  a_vector_clears_irq:
    assert property (wdogVectorAck |=> !wdogIrq) else $error("irq kept");
  a_vector_once:
    assert property (resetVectorStart |-> !internalReset ##1 !resetVectorStart)
      else $error("vector pulse wrong");
  a_wdog_pulse_short:
    assert property ($fell(portResetN) && resetPinN && powerGood && !brownoutLow
      && !scanResetBit |=> portResetN) else $error("pulse too long");
endmodule : reset_wdog_checker

bind system_reset_and_watchdog reset_wdog_checker #(.DELAY_CYC(DELAY_CYC)) chk_i (.*);

// file: test/core_model.sv
`timescale 1ns/10ps
module core_model #(
  parameter int ACK_LAT = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wdogIrq,
  input wire logic kick,
  input wire logic ackEn,
  output logic     watchdogRestart = 1'b0,
  output logic     wdogVectorAck = 1'b0
);
  int waitCnt = 0;
  always @(posedge ref_clk) watchdogRestart <= kick && !srst;
  ////////////////////////////////////////////////////////////////
  // the core is slow to enter the vector, as a busy one would be
  always @(posedge ref_clk) begin
    wdogVectorAck <= 1'b0;
    if (srst || !ackEn || !wdogIrq || wdogVectorAck) begin
      waitCnt <= 0;
    end else if (waitCnt == ACK_LAT) begin
      wdogVectorAck <= 1'b1;
      waitCnt <= 0;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end
endmodule : core_model

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
  import reset_wdog_pkg::*;
  localparam int DLY = 8;
  logic ref_clk = 1'b0, srst = 1'b1, powerGood = 1'b1, resetPinN = 1'b1, brownoutLow = 1'b0;
  logic scanResetBit = 1'b0, pin_reset_disable_fuse = 1'b0, watchdog_always_on_fuse = 1'b0;
  logic brownoutEnableFuse = 1'b0, comparator_bandgap_select = 1'b0, converterEnable = 1'b0;
  logic kick = 1'b0, ackEn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, portResetN, internalReset, resetVectorStart, wdogIrq, bandgapEnable;
  logic watchdogRestart, wdogVectorAck;
  int err_total = 0, samples_checked = 0;
  int n;
  system_reset_and_watchdog #(.DELAY_CYC(DLY), .BOD_FILTER_CYC(3), .OSC_DIV(4)) dut (.*);
  core_model core (.*);
  always #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) err_total++;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask : rd
  // s: 0 reset high, 1 irq high, 2 reset low
  task automatic wait_on(input int s, input int lim);
    n = 0;
    while ((s == 0 ? internalReset : s == 1 ? wdogIrq : !internalReset) !== 1'b1
           && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_on
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(WATCHDOG_CONTROL_STATUS_ADDR, WDOG_CTRL_RESET);
    rd(RESET_CAUSE_ADDR, 8'h01);
    rd(RESET_CONTROL_ADDR, {6'h00, BOOT_CTRL_RESET});
    wr(RESET_CONTROL_ADDR, 8'hFF);
    rd(RESET_CONTROL_ADDR, 8'h03);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
  endtask : t_regs
  task automatic t_bandgap;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {brownoutEnableFuse, comparator_bandgap_select, converterEnable} <= 3'(i);
      #1 chk(bandgapEnable, i != 0);
    end
    rd(STATUS_ADDR, 8'h04);
  endtask : t_bandgap
  task automatic t_sources;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      powerGood <= (i != 0);
      resetPinN <= (i != 1);
      brownoutLow <= (i == 2);
      scanResetBit <= (i == 3);
      #1 chk(portResetN, 0);
      repeat (10) @(posedge ref_clk);
      chk(internalReset, 1);
      {powerGood, resetPinN, brownoutLow, scanResetBit} <= 4'hC;
      wait_on(2, 100);
      chk(n >= DLY && n < 30, 1);
    end
    pin_reset_disable_fuse <= 1'b1;
    resetPinN <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk({portResetN, internalReset}, 2'b10);
    resetPinN <= 1'b1;
    brownoutLow <= 1'b1;
    // two cycles pass the synchroniser but stay below the filter count
    repeat (2) @(posedge ref_clk);
    brownoutLow <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(internalReset, 0);
  endtask : t_sources
  task automatic t_wdog;
    logic [7:0] q;
    wr(8'h00, 8'h18);
    repeat (6) @(posedge ref_clk);
    wr(8'h00, 8'h0B);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h09);
    rd(8'h00, 8'h09);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h09);
    wait_on(0, 20000);
    chk(n > 16300 && n < 16420, 1);
    wait_on(2, 100);
    bus(1'b0, 8'h04, 8'h00, q);
    chk(q[3], 1);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h08);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
  endtask : t_wdog
  task automatic t_combined;
    kick <= 1'b1;
    wr(8'h00, 8'h48);
    repeat (10000) @(posedge ref_clk);
    chk({wdogIrq, internalReset}, 2'b00);
    kick <= 1'b0;
    wait_on(1, 9000);
    chk(n < 9000, 1);
    rd(8'h00, 8'hC8);
    ackEn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(wdogIrq, 0);
    rd(8'h00, 8'h08);
    ackEn <= 1'b0;
    wait_on(0, 9000);
    chk(n < 9000, 1);
    wait_on(2, 100);
    watchdog_always_on_fuse <= 1'b1;
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h08);
  endtask : t_combined
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    wait_on(2, 100);
    t_regs;
    t_bandgap;
    t_sources;
    t_wdog;
    t_combined;
    report_and_stop;
  end
  // the longest path is about 45k cycles of watchdog waits
  initial begin
    #3200000;
    err_total++;
    report_and_stop;
  end
endmodule : tb
